// *** design/dds_ctrl_pkg.sv ***
// Package: register map, field positions, reset values and timing of the DDS control bank.
// Assumes one system clock; the register buffers are loaded by the serial port logic outside.
`default_nettype none
package dds_ctrl_pkg;
   // Register indices as seen by the serial port
   localparam logic [2:0] ADDR_CONTROL_WORD_A = 3'h0;
   localparam logic [2:0] ADDR_CONTROL_WORD_B = 3'h1;
   localparam logic [2:0] ADDR_AMPLITUDE_SCALE = 3'h2;
   localparam logic [2:0] ADDR_AMPLITUDE_RAMP_RATE = 3'h3;
   localparam logic [2:0] ADDR_FREQUENCY_TUNING_WORD = 3'h4;
   localparam logic [2:0] ADDR_PHASE_OFFSET_WORD = 3'h5;
   // Widths
   localparam int CWA_W = 32;
   localparam int CWB_W = 24;
   localparam int ASF_W = 16;
   localparam int ARR_W = 8;
   localparam int FTW_W = 32;
   localparam int POW_W = 14;
   localparam int SCALE_W = 14;
   localparam int MULT_W = 5;
   // Control word A bit positions
   localparam int CWA_RAMP_LOAD_UPD = 26;
   localparam int CWA_KEY_EN = 25;
   localparam int CWA_KEY_AUTO = 24;
   localparam int CWA_AUTO_SYNC = 23;
   localparam int CWA_SW_SYNC = 22;
   localparam int CWA_AUTO_CLR = 13;
   localparam int CWA_SINE_SEL = 12;
   localparam int CWA_CLR_ACC = 10;
   localparam int CWA_SDIO_IN_ONLY = 9;
   localparam int CWA_LSB_FIRST = 8;
   localparam int CWA_DIG_PD = 7;
   localparam int CWA_DAC_PD = 5;
   localparam int CWA_CLK_IN_PD = 4;
   localparam int CWA_EXT_PD_FULL = 3;
   localparam int CWA_SYNC_OUT_DIS = 1;
   // Control word B bit positions
   localparam int CWB_HS_SYNC = 11;
   localparam int CWB_HW_SYNC = 10;
   localparam int CWB_XTAL_OUT = 9;
   localparam int CWB_MULT_LSB = 3;
   localparam int CWB_VCO_HIGH = 2;
   localparam int CWB_CP_LSB = 0;
   // Amplitude scale fields
   localparam int ASF_STEP_LSB = 14;
   // Writable bits; everything else reads as zero
   localparam logic [CWA_W-1:0] CWA_MASK = 32'h07C0_37BA;
   localparam logic [CWB_W-1:0] CWB_MASK = 24'h00_0EFF;
   // Reset values
   localparam logic [CWA_W-1:0] CWA_RESET = 32'h0000_0000;
   localparam logic [CWB_W-1:0] CWB_RESET = 24'h00_0000;
   localparam logic [ASF_W-1:0] ASF_RESET = 16'h0000;
   localparam logic [ARR_W-1:0] ARR_RESET = 8'h00;
   localparam logic [FTW_W-1:0] FTW_RESET = 32'h0000_0000;
   localparam logic [POW_W-1:0] POW_RESET = 14'h0000;
   // Multiplier range
   localparam logic [MULT_W-1:0] MULT_MIN = 5'h04;
   localparam logic [MULT_W-1:0] MULT_MAX = 5'h14;
   // Sync clock: system clock divided by four, rising edge at count zero
   localparam int SYNC_DIV = 4;
   localparam logic [1:0] SYNC_RISE = 2'h0;
   localparam logic [1:0] SYNC_HIGH_END = 2'h1;
   localparam logic [SCALE_W-1:0] TIMER_TIMEOUT = 14'h0001;
endpackage
`default_nettype wire

// *** design/keying_if.sv ***
// Interface between the register bank and the shaped keying ramp.
// Assumes both ends run on the same system clock.
`default_nettype none
interface keying_if;
   logic auto_en;
   logic load_on_update;
   logic update;
   logic suspend;
   logic key_pin;
   logic [dds_ctrl_pkg::ARR_W-1:0] rate;
   logic [1:0] step_code;
   logic [dds_ctrl_pkg::SCALE_W-1:0] ceiling;
   logic [dds_ctrl_pkg::SCALE_W-1:0] scale;
   modport ctrl (output auto_en, output load_on_update, output update, output suspend, output key_pin,
      output rate, output step_code, output ceiling, input scale);
   modport ramp (input auto_en, input load_on_update, input update, input suspend, input key_pin,
      input rate, input step_code, input ceiling, output scale);
endinterface
`default_nettype wire

// *** design/keying_ramp.sv ***
// Automatic shaped keying: ramp rate timer and amplitude scale counter.
// Assumes the keying pin is synchronous to the system clock.
`default_nettype none
module keying_ramp (
   input wire logic i_clk,
   input wire logic i_arst_n,
   keying_if.ramp k
);
   typedef struct packed {
      logic [dds_ctrl_pkg::ARR_W-1:0] timer;
      logic [dds_ctrl_pkg::SCALE_W-1:0] scale;
      logic pin;
      logic auto_en;
   } ramp_state_t;

   ramp_state_t s_q, s_d;

   function automatic logic [dds_ctrl_pkg::SCALE_W:0] step_size(input logic [1:0] code);
      step_size = (dds_ctrl_pkg::SCALE_W+1)'(1) << code;
   endfunction

   logic timeout;
   logic force_load;
   logic [dds_ctrl_pkg::SCALE_W:0] up;
   logic [dds_ctrl_pkg::SCALE_W:0] step;

   always_comb begin
      s_d = s_q;
      s_d.pin = k.key_pin;
      s_d.auto_en = k.auto_en;
      step = step_size(k.step_code);
      up = {1'b0, s_q.scale} + step;
      // Zero is treated as a timeout as well so a cleared rate does not stall the timer
      timeout = (s_q.timer <= dds_ctrl_pkg::TIMER_TIMEOUT[dds_ctrl_pkg::ARR_W-1:0]);
      force_load = (k.key_pin != s_q.pin) || (k.auto_en && !s_q.auto_en)
         || (k.load_on_update && k.update);
      if (!k.auto_en) begin
         s_d.scale = '0;
         s_d.timer = k.rate;
      end else if (!k.suspend) begin
         if (timeout || force_load) begin
            s_d.timer = k.rate;
         end else begin
            s_d.timer = s_q.timer - 1'b1;
         end
         if (timeout) begin
            if (k.key_pin) begin
               s_d.scale = (up > {1'b0, k.ceiling}) ? k.ceiling : up[dds_ctrl_pkg::SCALE_W-1:0];
            end else if ({1'b0, s_q.scale} > step) begin
               s_d.scale = s_q.scale - step[dds_ctrl_pkg::SCALE_W-1:0];
            end else begin
               s_d.scale = '0;
            end
         end
         if (!k.key_pin && s_d.scale > k.ceiling) begin
            s_d.scale = k.ceiling;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign k.scale = s_q.scale;
endmodule
`default_nettype wire

// *** design/dds_control_register_bank.sv ***
// Control register bank of a direct digital synthesizer with its phase path and sync clock.
// Assumes the serial port logic writes the buffers and the update pin is synchronous to i_clk.
//
// Functional notes
// - Bit 26 low: ramp timer reloads on timeout, keying pin change or auto enable.
// - Bit 26 high: update strobe also reloads timer.
// - Bit 25 clear bypasses amplitude scaling.
// - Manual keying multiplies samples by scale factor.
// - Auto keying ramps scale following keying pin.
// - Bit 23 aligns sync clock to sync input.
// - Bit 22 resets sync divider to rising-edge count zero, then self-clears.
// - Bit 13 clears accumulator once per update.
// - Bit 12 selects sine, else cosine.
// - Bit 10 holds accumulator at zero.
// - Bit 9 makes serial data pin input-only.
// - Bit 8 selects least-significant bit first.
// - Bit 7 suspends accumulator, phase, converter and ramp logic.
// - Bits 5, 4 power down converter, clock input.
// - Power-down pin acts per bit 3 mode.
// - Bit 1 holds sync clock pin low.
// - Hardware sync advances one clock per edge.
// - Multiplier 4 to 20, otherwise bypassed.
// - Scale register gives step and ceiling.
// - Ramp rate sets scale counter stepping interval.
// - Tuning word is the accumulator increment.
// - Phase offset added to accumulator output.
// - Step codes give 1, 2, 4, 8.
// - Ramp timer reloads at one, clocking scale.
// - Sync clock is clock/4; update sampled there.
// - Writes land in buffers until update.
`default_nettype none
module dds_control_register_bank (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_wr_en,
   input wire logic [2:0] i_wr_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic [2:0] i_rd_addr,
   output logic [31:0] o_rd_data,
   input wire logic i_io_update,
   input wire logic i_sync_in,
   input wire logic i_shaped_keying_pin,
   input wire logic i_external_power_down_pin,
   input wire logic [13:0] i_amp_sample,
   output logic o_sync_clk,
   output logic [31:0] o_phase_acc,
   output logic [13:0] o_phase_word,
   output logic [13:0] o_dac_data,
   output logic [13:0] o_amplitude_scale_value,
   output logic o_sine_sel,
   output logic o_sdio_input_only,
   output logic o_lsb_first,
   output logic o_digital_pd,
   output logic o_dac_pd,
   output logic o_clk_in_pd,
   output logic o_pll_pd,
   output logic [4:0] o_pll_mult,
   output logic o_pll_bypass,
   output logic o_vco_high_range,
   output logic [1:0] o_cp_current,
   output logic o_crystal_out_en,
   output logic o_hs_sync_en
);
   typedef struct packed {
      logic [dds_ctrl_pkg::CWA_W-1:0] cwa_buf;
      logic [dds_ctrl_pkg::CWA_W-1:0] cwa;
      logic [dds_ctrl_pkg::CWB_W-1:0] cwb_buf;
      logic [dds_ctrl_pkg::CWB_W-1:0] cwb;
      logic [dds_ctrl_pkg::ASF_W-1:0] asf_buf;
      logic [dds_ctrl_pkg::ASF_W-1:0] amplitude_scale;
      logic [dds_ctrl_pkg::ARR_W-1:0] arr_buf;
      logic [dds_ctrl_pkg::ARR_W-1:0] amplitude_ramp_rate;
      logic [dds_ctrl_pkg::FTW_W-1:0] ftw_buf;
      logic [dds_ctrl_pkg::FTW_W-1:0] ftw;
      logic [dds_ctrl_pkg::POW_W-1:0] pow_buf;
      logic [dds_ctrl_pkg::POW_W-1:0] phase_offset_word;
      logic [dds_ctrl_pkg::FTW_W-1:0] acc;
      logic [1:0] div;
      logic sync_in;
      logic sync_clk;
      logic [dds_ctrl_pkg::POW_W-1:0] phase;
      logic [dds_ctrl_pkg::SCALE_W-1:0] dac;
   } bank_state_t;

   bank_state_t s_q, s_d;

   keying_if key_bus ();

   keying_ramp u_ramp (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .k(key_bus.ramp)
   );

   function automatic logic mult_in_range(input logic [dds_ctrl_pkg::MULT_W-1:0] m);
      mult_in_range = (m >= dds_ctrl_pkg::MULT_MIN) && (m <= dds_ctrl_pkg::MULT_MAX);
   endfunction

   function automatic logic [31:0] read_mux(input bank_state_t s, input logic [2:0] a);
      unique case (a)
         dds_ctrl_pkg::ADDR_CONTROL_WORD_A: read_mux = s.cwa_buf;
         dds_ctrl_pkg::ADDR_CONTROL_WORD_B: read_mux = {8'h00, s.cwb_buf};
         dds_ctrl_pkg::ADDR_AMPLITUDE_SCALE: read_mux = {16'h0000, s.asf_buf};
         dds_ctrl_pkg::ADDR_AMPLITUDE_RAMP_RATE: read_mux = {24'h00_0000, s.arr_buf};
         dds_ctrl_pkg::ADDR_FREQUENCY_TUNING_WORD: read_mux = s.ftw_buf;
         dds_ctrl_pkg::ADDR_PHASE_OFFSET_WORD: read_mux = {18'h0_0000, s.pow_buf};
         default: read_mux = 32'h0000_0000;
      endcase
   endfunction

   logic update_take;
   logic sync_rise_in;
   logic ext_full;
   logic suspend;
   logic key_en;
   logic key_auto;
   logic [dds_ctrl_pkg::SCALE_W-1:0] scale_sel;
   logic [2*dds_ctrl_pkg::SCALE_W-1:0] product;
   logic [dds_ctrl_pkg::POW_W-1:0] acc_top;

   // Update pin counts only at the sync clock rising edge
   assign update_take = i_io_update && (s_q.div == dds_ctrl_pkg::SYNC_RISE);
   assign sync_rise_in = i_sync_in && !s_q.sync_in;
   assign ext_full = i_external_power_down_pin && s_q.cwa[dds_ctrl_pkg::CWA_EXT_PD_FULL];
   assign suspend = s_q.cwa[dds_ctrl_pkg::CWA_DIG_PD] || i_external_power_down_pin;
   assign key_en = s_q.cwa[dds_ctrl_pkg::CWA_KEY_EN];
   assign key_auto = key_en && s_q.cwa[dds_ctrl_pkg::CWA_KEY_AUTO];

   always_comb begin
      key_bus.auto_en = key_auto;
      key_bus.load_on_update = s_q.cwa[dds_ctrl_pkg::CWA_RAMP_LOAD_UPD];
      key_bus.update = update_take;
      key_bus.suspend = suspend;
      key_bus.key_pin = i_shaped_keying_pin;
      key_bus.rate = s_q.amplitude_ramp_rate;
      key_bus.step_code = s_q.amplitude_scale[dds_ctrl_pkg::ASF_W-1:dds_ctrl_pkg::ASF_STEP_LSB];
      key_bus.ceiling = s_q.amplitude_scale[dds_ctrl_pkg::SCALE_W-1:0];
   end

   always_comb begin
      if (key_auto) begin
         scale_sel = key_bus.scale;
      end else begin
         scale_sel = s_q.amplitude_scale[dds_ctrl_pkg::SCALE_W-1:0];
      end
      product = i_amp_sample * scale_sel;
      acc_top = s_q.acc[dds_ctrl_pkg::FTW_W-1 -: dds_ctrl_pkg::POW_W];
   end

   always_comb begin
      s_d = s_q;
      s_d.sync_in = i_sync_in;

      // Buffered serial writes; the serial port keeps working while suspended
      if (i_wr_en) begin
         unique case (i_wr_addr)
            dds_ctrl_pkg::ADDR_CONTROL_WORD_A: s_d.cwa_buf = i_wr_data & dds_ctrl_pkg::CWA_MASK;
            dds_ctrl_pkg::ADDR_CONTROL_WORD_B: begin
               s_d.cwb_buf = i_wr_data[dds_ctrl_pkg::CWB_W-1:0] & dds_ctrl_pkg::CWB_MASK;
            end
            dds_ctrl_pkg::ADDR_AMPLITUDE_SCALE: s_d.asf_buf = i_wr_data[dds_ctrl_pkg::ASF_W-1:0];
            dds_ctrl_pkg::ADDR_AMPLITUDE_RAMP_RATE: s_d.arr_buf = i_wr_data[dds_ctrl_pkg::ARR_W-1:0];
            dds_ctrl_pkg::ADDR_FREQUENCY_TUNING_WORD: s_d.ftw_buf = i_wr_data;
            dds_ctrl_pkg::ADDR_PHASE_OFFSET_WORD: s_d.pow_buf = i_wr_data[dds_ctrl_pkg::POW_W-1:0];
            default: ;
         endcase
      end

      // Commit the buffers on an accepted update
      if (update_take) begin
         s_d.cwa = s_q.cwa_buf;
         s_d.cwb = s_q.cwb_buf;
         s_d.amplitude_scale = s_q.asf_buf;
         s_d.amplitude_ramp_rate = s_q.arr_buf;
         s_d.ftw = s_q.ftw_buf;
         s_d.phase_offset_word = s_q.pow_buf;
      end

      // Sync clock divider and its alignment modes
      s_d.div = s_q.div + 2'h1;
      if (s_q.cwa[dds_ctrl_pkg::CWA_AUTO_SYNC]) begin
         if (sync_rise_in) begin
            s_d.div = dds_ctrl_pkg::SYNC_RISE;
         end
      end else if (s_q.cwb[dds_ctrl_pkg::CWB_HW_SYNC] && sync_rise_in) begin
         s_d.div = s_q.div + 2'h2;
      end else if (s_q.cwa[dds_ctrl_pkg::CWA_SW_SYNC]) begin
         s_d.div = dds_ctrl_pkg::SYNC_RISE;
      end

      // Software sync is a one-shot; a new write in this cycle wins over the clear
      if (s_q.cwa[dds_ctrl_pkg::CWA_SW_SYNC]) begin
         s_d.cwa[dds_ctrl_pkg::CWA_SW_SYNC] = 1'b0;
         if (!(i_wr_en && i_wr_addr == dds_ctrl_pkg::ADDR_CONTROL_WORD_A
               && i_wr_data[dds_ctrl_pkg::CWA_SW_SYNC])) begin
            s_d.cwa_buf[dds_ctrl_pkg::CWA_SW_SYNC] = 1'b0;
         end
      end

      // Internal timing keeps running; only the pin is forced low
      s_d.sync_clk = (s_d.div <= dds_ctrl_pkg::SYNC_HIGH_END)
         && !s_d.cwa[dds_ctrl_pkg::CWA_SYNC_OUT_DIS];

      // Phase accumulator
      if (s_q.cwa[dds_ctrl_pkg::CWA_CLR_ACC]) begin
         s_d.acc = '0;
      end else if (update_take && s_q.cwa_buf[dds_ctrl_pkg::CWA_AUTO_CLR]) begin
         s_d.acc = '0;
      end else if (!suspend) begin
         s_d.acc = s_q.acc + s_q.ftw;
      end

      // Phase word and scaled converter sample
      if (!suspend) begin
         s_d.phase = acc_top + s_q.phase_offset_word;
         if (key_en) begin
            s_d.dac = product[2*dds_ctrl_pkg::SCALE_W-1:dds_ctrl_pkg::SCALE_W];
         end else begin
            s_d.dac = i_amp_sample;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      o_rd_data = read_mux(s_q, i_rd_addr);
      o_sync_clk = s_q.sync_clk;
      o_phase_acc = s_q.acc;
      o_phase_word = s_q.phase;
      o_dac_data = s_q.dac;
      o_amplitude_scale_value = scale_sel;
      o_sine_sel = s_q.cwa[dds_ctrl_pkg::CWA_SINE_SEL];
      o_sdio_input_only = s_q.cwa[dds_ctrl_pkg::CWA_SDIO_IN_ONLY];
      o_lsb_first = s_q.cwa[dds_ctrl_pkg::CWA_LSB_FIRST];
      o_digital_pd = suspend;
      o_dac_pd = s_q.cwa[dds_ctrl_pkg::CWA_DAC_PD] || i_external_power_down_pin;
      o_clk_in_pd = s_q.cwa[dds_ctrl_pkg::CWA_CLK_IN_PD] || ext_full;
      o_pll_pd = ext_full;
      o_pll_mult = s_q.cwb[dds_ctrl_pkg::CWB_MULT_LSB +: dds_ctrl_pkg::MULT_W];
      o_pll_bypass = !mult_in_range(o_pll_mult);
      o_vco_high_range = s_q.cwb[dds_ctrl_pkg::CWB_VCO_HIGH];
      o_cp_current = s_q.cwb[dds_ctrl_pkg::CWB_CP_LSB +: 2];
      o_crystal_out_en = s_q.cwb[dds_ctrl_pkg::CWB_XTAL_OUT];
      o_hs_sync_en = s_q.cwb[dds_ctrl_pkg::CWB_HS_SYNC];
   end
endmodule
`default_nettype wire

// *** testbench/dds_control_register_bank_sva.sv ***
// Checker: port-level assertions for the DDS control register bank.
// Assumes a single clock domain and is bound to every instance of the bank.
`default_nettype none
module dds_control_register_bank_sva (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_io_update,
   input wire logic i_external_power_down_pin,
   input wire logic [13:0] i_amp_sample,
   input wire logic o_sync_clk,
   input wire logic [31:0] o_phase_acc,
   input wire logic [13:0] o_phase_word,
   input wire logic [13:0] o_dac_data,
   input wire logic [13:0] o_amplitude_scale_value,
   input wire logic o_sine_sel,
   input wire logic o_sdio_input_only,
   input wire logic o_lsb_first,
   input wire logic o_digital_pd,
   input wire logic o_dac_pd,
   input wire logic o_clk_in_pd,
   input wire logic o_pll_pd,
   input wire logic [4:0] o_pll_mult,
   input wire logic o_pll_bypass
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] calm_q;
   logic [2:0] calm_d;
   // Cycles since the last update request or power-down, saturating
   always_comb begin
      calm_d = calm_q;
      if (i_io_update || o_digital_pd) begin
         calm_d = 3'h0;
      end else if (calm_q != 3'h7) begin
         calm_d = calm_q + 3'h1;
      end
   end
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         calm_q <= 3'h0;
      end else begin
         calm_q <= calm_d;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   chk_pd_pin_forces: assert property (i_external_power_down_pin |-> o_digital_pd && o_dac_pd)
      else $error("power-down pin left logic running");
   chk_full_pd_mode: assert property (o_pll_pd |-> i_external_power_down_pin && o_clk_in_pd && o_digital_pd)
      else $error("full power-down without pin or clock input");
   chk_mult_bypass: assert property (o_pll_bypass == (o_pll_mult < 5'h04 || o_pll_mult > 5'h14))
      else $error("multiplier bypass does not match field");
   chk_sync_fall: assert property ($rose(o_sync_clk) |-> ##[1:4] $fell(o_sync_clk))
      else $error("sync clock stuck high");
   chk_commit_gate: assert property (!$stable({o_sine_sel, o_sdio_input_only, o_lsb_first, o_pll_mult}) |-> $past(i_io_update))
      else $error("control output changed without update");
   chk_acc_step: assert property (calm_q >= 3'h4 |-> 32'(o_phase_acc - $past(o_phase_acc)) == 32'($past(o_phase_acc) - $past(o_phase_acc, 2)))
      else $error("accumulator step not constant");
   chk_phase_step: assert property (calm_q >= 3'h4 |-> 14'(o_phase_word - $past(o_phase_word)) == 14'($past(o_phase_acc[31:18]) - $past(o_phase_acc[31:18], 2)))
      else $error("phase word does not follow accumulator");
   chk_dac_path: assert property (calm_q >= 3'h4 |-> o_dac_data == $past(i_amp_sample) || o_dac_data == 14'((28'($past(i_amp_sample)) * 28'($past(o_amplitude_scale_value))) >> 14))
      else $error("converter data neither bypassed nor scaled");
   cover property ($fell(i_io_update));
   cover property (o_pll_pd);
   cover property (o_dac_data != $past(i_amp_sample));
endmodule
bind dds_control_register_bank dds_control_register_bank_sva dds_control_register_bank_sva_i (.i_clk, .i_arst_n,
   .i_io_update, .i_external_power_down_pin, .i_amp_sample, .o_sync_clk, .o_phase_acc, .o_phase_word, .o_dac_data,
   .o_amplitude_scale_value, .o_sine_sel, .o_sdio_input_only, .o_lsb_first, .o_digital_pd, .o_dac_pd, .o_clk_in_pd,
   .o_pll_pd, .o_pll_mult, .o_pll_bypass);
`default_nettype wire

// *** testbench/host_model.sv ***
// Host model: buffer writes from the serial port side and update strobes.
// Assumes the bank samples the update pin once per four system clocks.
`default_nettype none
module host_model (
   input wire logic i_clk,
   output logic o_wr_en,
   output logic [2:0] o_wr_addr,
   output logic [31:0] o_wr_data,
   output logic o_io_update
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_wr_en = 1'b0;
      o_wr_addr = 3'h0;
      o_wr_data = 32'h0000_0000;
      o_io_update = 1'b0;
   end
   task automatic write(input logic [2:0] addr, input logic [31:0] data);
      @(posedge i_clk);
      o_wr_en <= 1'b1;
      o_wr_addr <= addr;
      o_wr_data <= data;
      @(posedge i_clk);
      o_wr_en <= 1'b0;
      // Released bus shows the inverse so stale data cannot pass
      o_wr_data <= ~data;
   endtask
   // Held one whole sync period so exactly one sync rising edge samples it
   task automatic update();
      @(posedge i_clk);
      o_io_update <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_io_update <= 1'b0;
   endtask
endmodule
`default_nettype wire

// *** testbench/dds_control_register_bank_tb.sv ***
// Testbench: register readback, reset, control decode, phase path and keying ramp.
// Assumes host_model and the bound checker are compiled before this file.
`default_nettype none
module dds_control_register_bank_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [2:0] addr; logic [31:0] data; logic [31:0] exp;} row_t;
   row_t rows [8];
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic [2:0] i_rd_addr = 3'h0;
   logic i_sync_in = 1'b0;
   logic key_pin = 1'b0;
   logic pd_pin = 1'b0;
   logic [13:0] amp = 14'h0000;
   logic wr_en, upd;
   logic [2:0] wr_addr;
   logic [31:0] wr_data, rd_data, acc;
   logic [13:0] ph, dac, scale, v;
   logic sine, sdio, lsb, dig, dacpd, clkpd, pllpd, byp, sclk, vco, xtal, hss;
   logic [4:0] mult;
   logic [1:0] cp;
   logic [7:0] sh;
   int fails = 0;
   int num_checks = 0;
   always #2.5 i_clk = ~i_clk;
   host_model host_model_i (.i_clk(i_clk), .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data),
      .o_io_update(upd));
   dds_control_register_bank dds_control_register_bank_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_wr_en(wr_en),
      .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(i_rd_addr), .o_rd_data(rd_data), .i_io_update(upd),
      .i_sync_in(i_sync_in), .i_shaped_keying_pin(key_pin), .i_external_power_down_pin(pd_pin),
      .i_amp_sample(amp), .o_sync_clk(sclk), .o_phase_acc(acc), .o_phase_word(ph), .o_dac_data(dac),
      .o_amplitude_scale_value(scale), .o_sine_sel(sine), .o_sdio_input_only(sdio), .o_lsb_first(lsb),
      .o_digital_pd(dig), .o_dac_pd(dacpd), .o_clk_in_pd(clkpd), .o_pll_pd(pllpd), .o_pll_mult(mult),
      .o_pll_bypass(byp), .o_vco_high_range(vco), .o_cp_current(cp), .o_crystal_out_en(xtal),
      .o_hs_sync_en(hss));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic rd(input logic [2:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_rd_addr <= a;
      #1;
      check(rd_data, exp);
   endtask
   task automatic commit();
      host_model_i.update();
      repeat (2) @(posedge i_clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [31:0] d);
      host_model_i.write(a, d);
   endtask
   // Eight sync clock samples; sync input rises at the chosen edge
   task automatic sample_sync(input int rise_at);
      for (int n = 0; n < 8; n++) begin
         @(posedge i_clk);
         if (n == rise_at) begin
            i_sync_in <= 1'b1;
         end
         #1;
         sh = {sh[6:0], sclk};
      end
      @(posedge i_clk);
      i_sync_in <= 1'b0;
   endtask
   initial begin
      repeat (20000) @(posedge i_clk);
      fails++;
      finish_test();
   end
   initial begin
      rows = '{'{3'h0, 32'hFFFF_FFFF, dds_ctrl_pkg::CWA_MASK}, '{3'h1, 32'hFFFF_FFFF, {8'h00, dds_ctrl_pkg::CWB_MASK}},
         '{3'h2, 32'hFFFF_FFFF, 32'h0000_FFFF}, '{3'h3, 32'hFFFF_FFFF, 32'h0000_00FF},
         '{3'h4, 32'hA5A5_5A5A, 32'hA5A5_5A5A}, '{3'h5, 32'hFFFF_FFFF, 32'h0000_3FFF},
         '{3'h6, 32'hFFFF_FFFF, 32'h0000_0000}, '{3'h3, 32'h0000_0012, 32'h0000_0012}};
      repeat (4) @(posedge i_clk);
      i_arst_n <= 1'b1;
      foreach (rows[k]) begin
         wr(rows[k].addr, rows[k].data);
         rd(rows[k].addr, rows[k].exp);
      end
      $display("done: readback");
      @(posedge i_clk);
      i_arst_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      i_arst_n <= 1'b1;
      for (int a = 0; a < 6; a++) begin
         rd(3'(a), 32'h0000_0000);
      end
      check({byp, mult, sine, sdio, lsb, dig, dacpd, clkpd, pllpd}, {1'b1, 12'h000});
      $display("done: reset");
      wr(3'h0, 32'h0000_13B0);
      #1;
      check({sine, dig}, 2'h0);
      commit();
      check({sine, sdio, lsb, dig, dacpd, clkpd}, 6'h3F);
      wr(3'h0, 32'h0000_0008);
      commit();
      @(posedge i_clk);
      pd_pin <= 1'b1;
      #1;
      check({dig, dacpd, clkpd, pllpd}, 4'hF);
      wr(3'h0, 32'h0000_0000);
      commit();
      check({dig, dacpd, clkpd, pllpd}, 4'hC);
      @(posedge i_clk);
      pd_pin <= 1'b0;
      $display("done: power-down decode");
      for (int m = 0; m < 32; m++) begin
         wr(3'h1, 32'(m) << 3);
         commit();
         check({byp, mult}, {(m < 4 || m > 20), 5'(m)});
      end
      $display("done: multiplier");
      wr(3'h4, 32'h0100_0000);
      wr(3'h5, 32'h0000_1000);
      wr(3'h0, 32'h0000_0400);
      commit();
      repeat (2) @(posedge i_clk);
      #1;
      check(acc, 32'h0000_0000);
      check(ph, 14'h1000);
      wr(3'h0, 32'h0000_0000);
      commit();
      wr(3'h0, 32'h0000_2000);
      commit();
      check(acc < 32'h0800_0000, 1'b1);
      $display("done: phase path");
      @(posedge i_clk);
      amp <= 14'h3FFE;
      wr(3'h2, 32'h0000_E000);
      wr(3'h0, 32'h0200_0000);
      commit();
      check(dac, 14'h1FFF);
      wr(3'h0, 32'h0000_0000);
      commit();
      check(dac, 14'h3FFE);
      wr(3'h3, 32'h0000_0001);
      for (int c = 0; c < 4; c++) begin
         wr(3'h2, {16'h0000, 2'(c), 14'h0100});
         wr(3'h0, 32'h0300_0000);
         commit();
         @(posedge i_clk);
         key_pin <= 1'b1;
         repeat (8) @(posedge i_clk);
         #1;
         v = scale;
         @(posedge i_clk);
         #1;
         check(32'(scale - v), 32'h1 << c);
         repeat (300) @(posedge i_clk);
         #1;
         check(scale, 14'h0100);
         @(posedge i_clk);
         key_pin <= 1'b0;
         repeat (300) @(posedge i_clk);
         #1;
         check(scale, 14'h0000);
      end
      $display("done: keying ramp");
      wr(3'h3, 32'h0000_0004);
      commit();
      @(posedge i_clk);
      key_pin <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1;
      v = scale;
      repeat (8) @(posedge i_clk);
      #1;
      check(32'(scale - v), 32'h0000_0010);
      wr(3'h3, 32'h0000_0020);
      wr(3'h0, 32'h0700_0000);
      repeat (2) commit();
      v = scale;
      repeat (6) commit();
      check(scale, v);
      wr(3'h0, 32'h0300_0000);
      commit();
      v = scale;
      repeat (6) commit();
      check(scale > v, 1'b1);
      $display("done: ramp timer");
      wr(3'h1, 32'h0000_0E07);
      wr(3'h0, 32'h0080_0000);
      commit();
      check({vco, cp, xtal, hss}, 5'h1F);
      sample_sync(0);
      check(sh[6:0], 7'h66);
      wr(3'h0, 32'h0000_0000);
      commit();
      sample_sync(3);
      check(sh[3:0], {sh[6:4], sh[7]});
      wr(3'h0, 32'h0040_0000);
      commit();
      rd(3'h0, 32'h0000_0000);
      sample_sync(8);
      check($countones(sh), 4);
      wr(3'h0, 32'h0000_0002);
      commit();
      sample_sync(8);
      check(sh, 8'h00);
      $display("done: sync clock");
      finish_test();
   end
endmodule
`default_nettype wire
